/* src/csod_pkg.sv */
// constants shared by the clock status and output driver register bank
package csod_pkg;
  // ----------------------------------------------------------------
  // register port geometry
  // ----------------------------------------------------------------
  localparam int CSOD_ADDR_W = 10;
  localparam int CSOD_DATA_W = 8;
  localparam int CSOD_NUM_OUT = 12;
  localparam int CSOD_MON_W = 4;
  localparam logic [9:0] CSOD_STATUS_ADDR = 10'h01f;
  localparam logic [9:0] CSOD_FIRST_CLOCK_OUTPUT_CTL_ADDR = 10'h0f0;
  localparam logic [9:0] CSOD_NUM_OUT_ADDR = 10'h00c;
  // ----------------------------------------------------------------
  // status byte fields
  // ----------------------------------------------------------------
  localparam int CSOD_STAT_LOCK_BIT = 0;
  localparam int CSOD_STAT_PRIMARY_REFERENCE_INPUT_BIT = 1;
  localparam int CSOD_STAT_SECONDARY_REFERENCE_INPUT_BIT = 2;
  localparam int CSOD_STAT_OSC_BIT = 3;
  localparam logic [3:0] CSOD_MON_RESET = 4'h0;
  // ----------------------------------------------------------------
  // output control byte fields
  // ----------------------------------------------------------------
  localparam int CSOD_CTL_PD_BIT = 0;
  localparam int CSOD_CTL_SWING_LSB = 1;
  localparam int CSOD_CTL_POL_LSB = 3;
  localparam int CSOD_CTL_CMOS_LSB = 5;
  localparam int CSOD_CTL_FMT_BIT = 7;
  localparam logic CSOD_FMT_LVPECL = 1'b0;
  localparam logic CSOD_FMT_CMOS = 1'b1;
  localparam logic [1:0] CSOD_SWING_400MV = 2'h0;
  localparam logic [1:0] CSOD_SWING_600MV = 2'h1;
  localparam logic [1:0] CSOD_SWING_780MV = 2'h2;
  localparam logic [1:0] CSOD_SWING_960MV = 2'h3;
  // format lvpecl, both cmos legs on, polarity 00, 780 mV, powered
  localparam logic [7:0] CSOD_CTL_RESET = 8'h64;
  localparam logic [7:0] CSOD_READ_ZERO = 8'h00;
endpackage : csod_pkg

/* src/csod_out_decode.sv */
// per-output driver control decode with registered driver controls
`timescale 1ns/1ns
module csod_out_decode
  import csod_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // control byte of this output
  input wire logic [7:0] ctlByte,
  // driver controls
  output logic formatCmos,
  output logic legAEnable,
  output logic legBEnable,
  output logic legAInvert,
  output logic legBInvert,
  output logic [1:0] swing,
  output logic powerDown
);
  import csod_pkg::*;

  logic fmt;
  logic [1:0] cmosCfg;
  logic [1:0] pol;
  logic [6:0] drv_r;
  logic [6:0] drv_nxt;

  assign fmt = ctlByte[CSOD_CTL_FMT_BIT];
  assign cmosCfg = ctlByte[CSOD_CTL_CMOS_LSB +: 2];
  assign pol = ctlByte[CSOD_CTL_POL_LSB +: 2];

  always_comb begin
    drv_nxt[6] = fmt;
    if (fmt == CSOD_FMT_CMOS) begin
      drv_nxt[5] = cmosCfg[0];
      drv_nxt[4] = cmosCfg[1];
      drv_nxt[3] = pol[0];
      drv_nxt[2] = pol[0] ^ pol[1];
    end else begin
      // differential pair: both legs live unless powered down
      drv_nxt[5] = ~ctlByte[CSOD_CTL_PD_BIT];
      drv_nxt[4] = ~ctlByte[CSOD_CTL_PD_BIT];
      drv_nxt[3] = pol[0];
      drv_nxt[2] = ~pol[0];
    end
    drv_nxt[1:0] = ctlByte[CSOD_CTL_SWING_LSB +: 2];
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      drv_r <= 7'h02;
      powerDown <= 1'b0;
    end else begin
      drv_r <= drv_nxt;
      powerDown <= ctlByte[CSOD_CTL_PD_BIT];
    end
  end

  assign formatCmos = drv_r[6];
  assign legAEnable = drv_r[5];
  assign legBEnable = drv_r[4];
  assign legAInvert = drv_r[3];
  assign legBInvert = drv_r[2];
  assign swing = drv_r[1:0];

  a_cmos_leg_gate: assert property (
    @(posedge clock) disable iff (!reset_n)
    $past(reset_n) && $past(fmt) |-> {legAEnable, legBEnable} ==
    {$past(cmosCfg[0]), $past(cmosCfg[1])})
    else $error("cmos leg enables do not follow the configuration");
  a_lvpecl_polarity: assert property (
    @(posedge clock) disable iff (!reset_n)
    $past(reset_n) && !$past(fmt) |-> legAInvert == $past(pol[0]) &&
    legBInvert == !legAInvert)
    else $error("lvpecl polarity decode wrong");
  a_cmos_polarity: assert property (
    @(posedge clock) disable iff (!reset_n)
    $past(reset_n) && $past(fmt) && $past(pol) == 2'h0 |->
    !legAInvert && !legBInvert)
    else $error("cmos polarity 00 does not give noninverting legs");
  a_swing_power: assert property (
    @(posedge clock) disable iff (!reset_n)
    $past(reset_n) |-> swing == $past(ctlByte[2:1]) &&
    powerDown == $past(ctlByte[0]))
    else $error("swing or power-down does not follow control byte");
endmodule : csod_out_decode

/* src/csod_regs.sv */
// clock monitor status and output driver control register bank
//
// Functional notes
// - status bit 3 shows live oscillator-above-threshold flag; read-only
// - status bit 2 shows secondary reference above threshold; read-only
// - status bit 1 shows primary reference above threshold; read-only
// - status bit 0 shows pll digital lock; software cannot write it
// - control bit 7 picks driver format, 0 lvpecl default, 1 cmos
// - bits 2:1 pick lvpecl swing 400/600/780/960 mV, 780 default
// - bit 0 set puts lvpecl driver in safe power-down, default off
// - twelve control bytes at consecutive addresses share one layout
`timescale 1ns/1ns
module csod_regs
  import csod_pkg::*;
(
  // clock and reset of the control port
  input wire logic clock,
  input wire logic reset_n,
  // decoded register access from the serial control port
  input wire logic [csod_pkg::CSOD_ADDR_W-1:0] regAddr,
  input wire logic regWrite,
  input wire logic [csod_pkg::CSOD_DATA_W-1:0] regWriteData,
  input wire logic regRead,
  output logic [csod_pkg::CSOD_DATA_W-1:0] regReadData,
  output logic regReadValid,
  // live monitor results, asynchronous to clock
  input wire logic oscAboveThreshold,
  input wire logic primaryRefAboveThreshold,
  input wire logic secondaryRefAboveThreshold,
  input wire logic pllLocked,
  // per-output driver controls, bit n for output n, swing bits 2n+1:2n for output n
  output logic [csod_pkg::CSOD_NUM_OUT-1:0] outFormatCmos,
  output logic [csod_pkg::CSOD_NUM_OUT-1:0] legAEnable,
  output logic [csod_pkg::CSOD_NUM_OUT-1:0] legBEnable,
  output logic [csod_pkg::CSOD_NUM_OUT-1:0] legAInvert,
  output logic [csod_pkg::CSOD_NUM_OUT-1:0] legBInvert,
  output logic [2*csod_pkg::CSOD_NUM_OUT-1:0] outSwing,
  output logic [csod_pkg::CSOD_NUM_OUT-1:0] outPowerDown
);
  import csod_pkg::*;

  // ----------------------------------------------------------------
  // monitor synchronisers
  // ----------------------------------------------------------------
  logic [CSOD_MON_W-1:0] monPin;
  logic [CSOD_MON_W-1:0] monMeta_r;
  logic [CSOD_MON_W-1:0] monSync_r;
  logic [CSOD_MON_W-1:0] monMeta_nxt;
  logic [CSOD_MON_W-1:0] monSync_nxt;

  assign monPin[CSOD_STAT_OSC_BIT] = oscAboveThreshold;
  assign monPin[CSOD_STAT_SECONDARY_REFERENCE_INPUT_BIT] = secondaryRefAboveThreshold;
  assign monPin[CSOD_STAT_PRIMARY_REFERENCE_INPUT_BIT] = primaryRefAboveThreshold;
  assign monPin[CSOD_STAT_LOCK_BIT] = pllLocked;

  // the monitors run off their own clocks; two flops cost two cycles
  // of status lag but keep a metastable level away from the read mux
  always_comb begin
    monMeta_nxt = monPin;
    monSync_nxt = monMeta_r;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      monMeta_r <= CSOD_MON_RESET;
      monSync_r <= CSOD_MON_RESET;
    end else begin
      monMeta_r <= monMeta_nxt;
      monSync_r <= monSync_nxt;
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [CSOD_ADDR_W-1:0] ctlOffs;
  logic ctlHit;
  logic statusHit;
  logic [3:0] ctlIdx;

  always_comb begin
    // addresses below the first byte wrap high, so one compare suffices
    ctlOffs = regAddr - CSOD_FIRST_CLOCK_OUTPUT_CTL_ADDR;
    ctlHit = ctlOffs < CSOD_NUM_OUT_ADDR;
    ctlIdx = ctlOffs[3:0];
    statusHit = regAddr == CSOD_STATUS_ADDR;
  end

  // ----------------------------------------------------------------
  // output control bytes
  // ----------------------------------------------------------------
  logic [7:0] ctl_r [CSOD_NUM_OUT];
  logic [7:0] ctl_nxt [CSOD_NUM_OUT];

  always_comb begin
    for (int i = 0; i < CSOD_NUM_OUT; i++) begin
      ctl_nxt[i] = ctl_r[i];
    end
    // the status byte has no storage, so a write there just falls away
    if (regWrite && ctlHit) begin
      ctl_nxt[ctlIdx] = regWriteData;
    end
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < CSOD_NUM_OUT; i++) begin
      if (!reset_n) begin
        ctl_r[i] <= CSOD_CTL_RESET;
      end else begin
        ctl_r[i] <= ctl_nxt[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rdData_nxt;
  logic rdValid_nxt;

  always_comb begin
    rdValid_nxt = regRead;
    rdData_nxt = CSOD_READ_ZERO;
    if (regRead && statusHit) begin
      // upper status bits belong to other monitors and read zero here
      rdData_nxt[CSOD_STAT_OSC_BIT] =
        monSync_r[CSOD_STAT_OSC_BIT];
      rdData_nxt[CSOD_STAT_SECONDARY_REFERENCE_INPUT_BIT] =
        monSync_r[CSOD_STAT_SECONDARY_REFERENCE_INPUT_BIT];
      rdData_nxt[CSOD_STAT_PRIMARY_REFERENCE_INPUT_BIT] =
        monSync_r[CSOD_STAT_PRIMARY_REFERENCE_INPUT_BIT];
      rdData_nxt[CSOD_STAT_LOCK_BIT] =
        monSync_r[CSOD_STAT_LOCK_BIT];
    end else if (regRead && ctlHit) begin
      // a write on the same edge lands afterwards, so the old byte returns
      rdData_nxt = ctl_r[ctlIdx];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      regReadData <= CSOD_READ_ZERO;
      regReadValid <= 1'b0;
    end else begin
      regReadData <= rdData_nxt;
      regReadValid <= rdValid_nxt;
    end
  end

  // ----------------------------------------------------------------
  // per-output decoders
  // ----------------------------------------------------------------
  // flat copy of all control bytes, so checks can compare them at once
  logic [8*CSOD_NUM_OUT-1:0] ctlFlat;

  genvar g;
  generate
    for (g = 0; g < CSOD_NUM_OUT; g++) begin : gOut
      assign ctlFlat[8*g +: 8] = ctl_r[g];
      a_format_follow: assert property (
        @(posedge clock) disable iff (!reset_n)
        $past(reset_n) |->
        outFormatCmos[g] == $past(ctl_r[g][CSOD_CTL_FMT_BIT]))
        else $error("output format does not follow its control byte");
      csod_out_decode uDecode (
        .clock(clock),
        .reset_n(reset_n),
        .ctlByte(ctl_r[g]),
        .formatCmos(outFormatCmos[g]),
        .legAEnable(legAEnable[g]),
        .legBEnable(legBEnable[g]),
        .legAInvert(legAInvert[g]),
        .legBInvert(legBInvert[g]),
        .swing(outSwing[2*g +: 2]),
        .powerDown(outPowerDown[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_status_osc: assert property (
    @(posedge clock) disable iff (!reset_n)
    regRead && statusHit && $past(reset_n, 1) && $past(reset_n, 2) |=>
    regReadData[3] == $past(oscAboveThreshold, 3))
    else $error("status osc bit does not track monitor");
  a_status_refs: assert property (
    @(posedge clock) disable iff (!reset_n)
    regRead && statusHit && $past(reset_n, 1) && $past(reset_n, 2) |=>
    regReadData[2:1] == {$past(secondaryRefAboveThreshold, 3),
    $past(primaryRefAboveThreshold, 3)})
    else $error("status reference bits do not track monitors");
  a_status_lock: assert property (
    @(posedge clock) disable iff (!reset_n)
    regRead && statusHit && $past(reset_n, 1) && $past(reset_n, 2) |=>
    regReadData[0] == $past(pllLocked, 3) && regReadData[7:4] == 4'h0)
    else $error("status lock bit wrong or upper bits nonzero");
  a_status_nowrite: assert property (
    @(posedge clock) disable iff (!reset_n)
    regWrite && statusHit |=> ctlFlat == $past(ctlFlat))
    else $error("write to status byte changed state");
  a_unmapped_write: assert property (
    @(posedge clock) disable iff (!reset_n)
    regWrite && !ctlHit |=> ctlFlat == $past(ctlFlat))
    else $error("write outside the control bytes changed state");
  a_ctl_write: assert property (
    @(posedge clock) disable iff (!reset_n)
    regWrite && ctlHit ##1 regRead && regAddr == $past(regAddr) && !regWrite
    |=> regReadData == $past(regWriteData, 2))
    else $error("control byte readback mismatch");
  a_ctl_reset: assert property (@(posedge clock)
    !reset_n |=> ctl_r[0] == 8'h64 && ctl_r[11] == 8'h64)
    else $error("control byte reset value wrong");
  a_read_valid: assert property (@(posedge clock) disable iff (!reset_n)
    regRead |=> regReadValid &&
    ($past(ctlHit) || $past(statusHit) || regReadData == 8'h00))
    else $error("read answer missing or unmapped read not zero");
  a_read_quiet: assert property (@(posedge clock) disable iff (!reset_n)
    !regRead |=> !regReadValid && regReadData == 8'h00)
    else $error("read answer stands longer than one cycle");
  a_reset_quiet: assert property (@(posedge clock)
    !reset_n |=> !regReadValid && regReadData == 8'h00)
    else $error("read answer not cleared by reset");
endmodule : csod_regs

/* bench/csod_regs_tb.sv */
// self-checking bench for the clock status and output driver register bank
`timescale 1ns/1ns
module csod_regs_tb;
  import csod_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [9:0] regAddr = 10'h000;
  logic regWrite = 1'b0;
  logic [7:0] regWriteData = 8'h00;
  logic regRead = 1'b0;
  logic [7:0] regReadData;
  logic regReadValid;
  logic [3:0] mon = 4'h0;
  logic [11:0] outFormatCmos, legAEnable, legBEnable, legAInvert, legBInvert;
  logic [11:0] outPowerDown;
  logic [23:0] outSwing;
  logic [7:0] ctl [12];
  logic [7:0] expQ [$];
  int mismatches = 0;
  int checksDone = 0;
  logic [31:0] r;
  logic [9:0] a;
  csod_regs dut_u (.clock(clock), .reset_n(reset_n), .regAddr(regAddr),
    .regWrite(regWrite), .regWriteData(regWriteData), .regRead(regRead),
    .regReadData(regReadData), .regReadValid(regReadValid),
    .oscAboveThreshold(mon[3]), .secondaryRefAboveThreshold(mon[2]),
    .primaryRefAboveThreshold(mon[1]), .pllLocked(mon[0]),
    .outFormatCmos(outFormatCmos), .legAEnable(legAEnable),
    .legBEnable(legBEnable), .legAInvert(legAInvert),
    .legBInvert(legBInvert), .outSwing(outSwing),
    .outPowerDown(outPowerDown));
  initial begin
    forever #20 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // expected driver controls {fmt, enA, enB, invA, invB, swing, pd}
  function automatic logic [7:0] dec(logic [7:0] b);
    logic ea, eb, ib;
    ea = b[7] ? b[5] : !b[0];
    eb = b[7] ? b[6] : !b[0];
    ib = b[7] ? (b[3] ^ b[4]) : !b[3];
    return {b[7], ea, eb, b[3], ib, b[2:1], b[0]};
  endfunction : dec
  function automatic logic [7:0] rdExp(logic [9:0] ad);
    if (ad == CSOD_STATUS_ADDR) return {4'h0, mon};
    if (ad >= CSOD_FIRST_CLOCK_OUTPUT_CTL_ADDR && ad < CSOD_FIRST_CLOCK_OUTPUT_CTL_ADDR + 10'd12)
      return ctl[ad - CSOD_FIRST_CLOCK_OUTPUT_CTL_ADDR];
    return 8'h00;
  endfunction : rdExp
  // one request edge; read and write together return the old byte
  task automatic access(logic wr, logic rd, logic [9:0] ad, logic [7:0] d);
    regWrite = wr;
    regRead = rd;
    regAddr = ad;
    regWriteData = d;
    if (rd) expQ.push_back(rdExp(ad));
    if (wr && ad >= CSOD_FIRST_CLOCK_OUTPUT_CTL_ADDR && ad < CSOD_FIRST_CLOCK_OUTPUT_CTL_ADDR + 10'd12)
      ctl[ad - CSOD_FIRST_CLOCK_OUTPUT_CTL_ADDR] = d;
    @(posedge clock);
    #1;
  endtask : access
  // strobes stay up until the next access or this task replaces them
  task automatic idle();
    regWrite = 1'b0;
    regRead = 1'b0;
    @(posedge clock);
    #1;
  endtask : idle
  task automatic chkOuts();
    for (int n = 0; n < 12; n++) begin
      chk($sformatf("drive%0d", n), dec(ctl[n]), {outFormatCmos[n],
        legAEnable[n], legBEnable[n], legAInvert[n], legBInvert[n],
        outSwing[2*n+:2], outPowerDown[n]});
    end
  endtask : chkOuts
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------------------------------
  // read answer monitor
  // ----------------------------------------------------------------
  always @(negedge clock) begin
    if (regReadValid === 1'b1) begin
      if (expQ.size() == 0) begin
        chk("spare read", 8'h00, 8'hff);
      end else begin
        chk("readData", expQ.pop_front(), regReadData);
      end
    end
  end
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'ha174));
    for (int n = 0; n < 12; n++) ctl[n] = CSOD_CTL_RESET;
    repeat (5) @(posedge clock);
    #1;
    reset_n = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chkOuts();
    for (int n = 0; n < 13; n++) begin
      access(1'b0, 1'b1, CSOD_FIRST_CLOCK_OUTPUT_CTL_ADDR + n[9:0], 8'h00);
    end
    idle();
    for (int i = 0; i < 48; i++) begin
      mon = 4'($urandom());
      repeat (3) @(posedge clock);
      #1;
      r = $urandom();
      a = (r[3:0] < 4'h3) ? CSOD_STATUS_ADDR : CSOD_FIRST_CLOCK_OUTPUT_CTL_ADDR + r[7:4];
      access(1'b1, r[8], a, 8'($urandom()));
      access(1'b0, 1'b1, a, 8'h00);
      access(1'b0, 1'b1, CSOD_STATUS_ADDR, 8'h00);
      idle();
      repeat (2) @(posedge clock);
      #1;
      chkOuts();
    end
    repeat (3) @(posedge clock);
    chk("pending reads", 8'h00, 8'(expQ.size()));
    end_of_test();
  end
endmodule : csod_regs_tb
